// file: src/ppfm_consts.svh
// register indices, field positions, masks and reset values of the port pin mux
`ifndef PPFM_CONSTS_SVH
`define PPFM_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PPFM_IDX_P3_DATA 32'hffff_f406
`define PPFM_IDX_P3_DIR 32'hffff_f426
`define PPFM_IDX_P3_FUNC 32'hffff_f446
`define PPFM_IDX_P2_FUNC 32'hffff_f444
`define PPFM_IDX_P2_ALT 32'hffff_f464
`define PPFM_IDX_P3_ALT 32'hffff_f466

// ----------------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------------
`define PPFM_IDX_LSB 2
`define PPFM_IDX_W 11
`define PPFM_BIT_ALIAS_POS 13

// ----------------------------------------------------------------------------
// masked write fields in bit mode
// ----------------------------------------------------------------------------
`define PPFM_BIT_MASK_LSB 0
`define PPFM_BIT_VALUE_LSB 8

// ----------------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------------
`define PPFM_P3_MASK 8'h1f
`define PPFM_P2_ALT_MASK 8'h9e
`define PPFM_P3_ALT_MASK 8'h1c
`define PPFM_P3_DIR_FILL 8'he0
`define PPFM_RST_P3_DATA 8'h00
`define PPFM_RST_P3_DIR 8'hff
`define PPFM_RST_P3_FUNC 8'h00
`define PPFM_RST_P2_FUNC 8'h00
`define PPFM_RST_P2_ALT 8'h00
`define PPFM_RST_P3_ALT 8'h00

// ----------------------------------------------------------------------------
// pin positions
// ----------------------------------------------------------------------------
`define PPFM_P2_PIN7 7
`define PPFM_P3_PIN_RX0 0
`define PPFM_P3_PIN_TX0 1
`define PPFM_P3_PIN_RX1 2
`define PPFM_P3_PIN_TX1 3
`define PPFM_P3_PIN_CLK1 4

`endif

// file: src/ppfm_pkg.sv
// types shared by the port pin mux
package ppfm_pkg;

  // register selected by the current bus address
  typedef enum logic [2:0] {
    PPFM_SEL_NONE,
    PPFM_SEL_P3_DATA,
    PPFM_SEL_P3_DIR,
    PPFM_SEL_P3_FUNC,
    PPFM_SEL_P2_FUNC,
    PPFM_SEL_P2_ALT,
    PPFM_SEL_P3_ALT
  } ppfm_sel_t;

endpackage

// file: src/ppfm_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module ppfm_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: src/ppfm_top.sv
// port 2 alternate routing and port 3 pin control behind an apb slave
//
// How it works
// (RULE1) every register takes whole-byte access, and a bit-mode alias writes single bits by mask.
// (RULE2) software writes zero into port-2 selector bits 0, 5 and 6, which hold nothing.
// (RULE3) a port-2 pin in plain port mode ignores its selector bit.
// (RULE4) in control mode selector bits 7 and 4..1 pick interrupt input (0) or timer output (1).
// (RULE5) port 3 has five pins whose directions are set one by one.
// (RULE6) in control mode port-3 pins connect to the two serial units and the clocked unit.
// (RULE7) a port-3 direction bit of 0 turns the output buffer on, 1 makes an input; reset ff.
// (RULE8) port-3 function bits hand the pins to peripherals; bits 1 and 3 drive transmit data.
// (RULE9) function bits 0 and 2 feed receive inputs, bit 4 makes pin 4 the two-way clock.
// (RULE10) port-2 function bits of pins 7 and 4..1 pick port mode (0) or the alternate (1).
// (RULE11) port-3 selector bits 4..2 pick asynchronous (0) or clocked serial (1) functions.
// (RULE12) the port-3 data register writes the latch, reads pin for inputs, latch for outputs.
// (RULE13) direction bits 7..5 read 1, function bits 7..5 read 0, and writes to them do nothing.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ppfm_consts.svh"

module ppfm_top #(
  parameter int ADDR_W = 14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] p2_pin_in,
  output logic [7:0] p2_alt_out,
  output logic [7:0] p2_alt_oe,
  output logic [7:0] port2_function_enable,
  input wire logic timer3_out,
  input wire logic [3:0] timer2_outputs,
  output logic ext_irq_line31,
  output logic [3:0] ext_irq_lines_b,
  input wire logic [4:0] p3_pin_in,
  output logic [4:0] p3_pin_out,
  output logic [4:0] p3_pin_oe,
  input wire logic serial0_transmit,
  input wire logic serial1_transmit,
  input wire logic clocked_serial1_out,
  input wire logic serial1_baud_clock_out,
  input wire logic serial1_baud_clock_oe,
  input wire logic clocked_serial1_clock_out,
  input wire logic clocked_serial1_clock_oe,
  output logic serial0_receive,
  output logic serial1_receive,
  output logic clocked_serial1_in,
  output logic serial1_baud_clock,
  output logic clocked_serial1_clock
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [4:0] port3_pin_data_reg;
  logic [4:0] port3_direction_reg;
  logic [4:0] port3_function_enable_reg;
  logic [7:0] port2_function_enable_reg;
  logic [7:0] port2_alternate_select_reg;
  logic [7:0] port3_alternate_select_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // synchronised pin levels
  logic [7:0] p2_pin_sync;
  logic [4:0] p3_pin_sync;

  // bus decode
  ppfm_pkg::ppfm_sel_t sel;
  logic bit_mode;
  logic wr_en;
  logic [7:0] cur_val;
  logic [7:0] wr_val;
  logic [7:0] rd_val;
  logic [4:0] p3_read;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  ppfm_sync #(
    .WIDTH(13)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({p2_pin_in, p3_pin_in}),
    .sync_out({p2_pin_sync, p3_pin_sync})
  );

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------

  // pick the register from the word index, upper address bits ignored
  always_comb begin
    case (paddr[`PPFM_IDX_W+`PPFM_IDX_LSB-1:`PPFM_IDX_LSB])
      `PPFM_IDX_W'(`PPFM_IDX_P3_DATA): sel = ppfm_pkg::PPFM_SEL_P3_DATA;
      `PPFM_IDX_W'(`PPFM_IDX_P3_DIR): sel = ppfm_pkg::PPFM_SEL_P3_DIR;
      `PPFM_IDX_W'(`PPFM_IDX_P3_FUNC): sel = ppfm_pkg::PPFM_SEL_P3_FUNC;
      `PPFM_IDX_W'(`PPFM_IDX_P2_FUNC): sel = ppfm_pkg::PPFM_SEL_P2_FUNC;
      `PPFM_IDX_W'(`PPFM_IDX_P2_ALT): sel = ppfm_pkg::PPFM_SEL_P2_ALT;
      `PPFM_IDX_W'(`PPFM_IDX_P3_ALT): sel = ppfm_pkg::PPFM_SEL_P3_ALT;
      default: sel = ppfm_pkg::PPFM_SEL_NONE;
    endcase
  end

  // alias bit selects masked single-bit writes
  assign bit_mode = paddr[`PPFM_BIT_ALIAS_POS];

  // write takes effect at the access edge, lane 0 only
  assign wr_en = psel & penable & pwrite & pstrb[0];

  // --------------------------------------------------------------------------
  // read view of each register
  // --------------------------------------------------------------------------

  // data read: pin level for inputs, latch for outputs
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      p3_read[i] = port3_direction_reg[i] ? p3_pin_sync[i] : port3_pin_data_reg[i]; // RULE12
    end
  end

  // current byte of the selected register, unused bits filled
  always_comb begin
    case (sel)
      ppfm_pkg::PPFM_SEL_P3_DATA: rd_val = {3'h0, p3_read};
      ppfm_pkg::PPFM_SEL_P3_DIR: rd_val = `PPFM_P3_DIR_FILL | {3'h0, port3_direction_reg}; // RULE13
      ppfm_pkg::PPFM_SEL_P3_FUNC: rd_val = {3'h0, port3_function_enable_reg}; // RULE13
      ppfm_pkg::PPFM_SEL_P2_FUNC: rd_val = port2_function_enable_reg;
      ppfm_pkg::PPFM_SEL_P2_ALT: rd_val = port2_alternate_select_reg;
      ppfm_pkg::PPFM_SEL_P3_ALT: rd_val = port3_alternate_select_reg;
      default: rd_val = 8'h00;
    endcase
  end

  // stored value that a bit-mode write merges into
  always_comb begin
    case (sel)
      ppfm_pkg::PPFM_SEL_P3_DATA: cur_val = {3'h0, port3_pin_data_reg};
      default: cur_val = rd_val;
    endcase
  end

  // byte write, or masked merge in bit mode
  always_comb begin
    if (bit_mode) begin
      wr_val = (cur_val & ~pwdata[`PPFM_BIT_MASK_LSB+:8])
             | (pwdata[`PPFM_BIT_VALUE_LSB+:8] & pwdata[`PPFM_BIT_MASK_LSB+:8]); // RULE1
    end else begin
      wr_val = pwdata[7:0]; // RULE1
    end
  end

  // --------------------------------------------------------------------------
  // apb answer
  // --------------------------------------------------------------------------

  // capture read data and error in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pslverr_reg <= (sel == ppfm_pkg::PPFM_SEL_NONE);
    end
  end

  // zero wait states
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // --------------------------------------------------------------------------
  // port 3 registers
  // --------------------------------------------------------------------------

  // output latch, written in any mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port3_pin_data_reg <= 5'(`PPFM_RST_P3_DATA);
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P3_DATA) begin
      port3_pin_data_reg <= wr_val[4:0]; // RULE12
    end
  end

  // per-pin direction, all inputs after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port3_direction_reg <= 5'(`PPFM_RST_P3_DIR); // RULE7
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P3_DIR) begin
      port3_direction_reg <= wr_val[4:0]; // RULE5 RULE13
    end
  end

  // port or peripheral per pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port3_function_enable_reg <= 5'(`PPFM_RST_P3_FUNC); // RULE8
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P3_FUNC) begin
      port3_function_enable_reg <= wr_val[4:0]; // RULE13
    end
  end

  // asynchronous or clocked serial choice, bits 4..2 kept
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port3_alternate_select_reg <= `PPFM_RST_P3_ALT;
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P3_ALT) begin
      port3_alternate_select_reg <= wr_val & `PPFM_P3_ALT_MASK; // RULE11
    end
  end

  // --------------------------------------------------------------------------
  // port 2 registers
  // --------------------------------------------------------------------------

  // port or alternate per pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port2_function_enable_reg <= `PPFM_RST_P2_FUNC; // RULE10
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P2_FUNC) begin
      port2_function_enable_reg <= wr_val;
    end
  end

  // selector, bits 0, 5 and 6 hold nothing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port2_alternate_select_reg <= `PPFM_RST_P2_ALT; // RULE4
    end else if (wr_en && sel == ppfm_pkg::PPFM_SEL_P2_ALT) begin
      port2_alternate_select_reg <= wr_val & `PPFM_P2_ALT_MASK; // RULE2
    end
  end

  assign port2_function_enable = port2_function_enable_reg;

  // --------------------------------------------------------------------------
  // port 2 routing
  // --------------------------------------------------------------------------

  // timer outputs for pins 4..1 and 7, selector ignored in port mode
  generate
    for (genvar i = 0; i < 8; i++) begin : g_p2
      if (i >= 1 && i <= 4) begin : g_timer2
        assign p2_alt_oe[i] = port2_function_enable_reg[i]
                            & port2_alternate_select_reg[i]; // RULE3 RULE4 RULE10
        assign p2_alt_out[i] = timer2_outputs[i-1];
        assign ext_irq_lines_b[i-1] = port2_function_enable_reg[i]
                                    & ~port2_alternate_select_reg[i]
                                    & p2_pin_sync[i]; // RULE3 RULE4 RULE10
      end else if (i == `PPFM_P2_PIN7) begin : g_timer3
        assign p2_alt_oe[i] = port2_function_enable_reg[i]
                            & port2_alternate_select_reg[i]; // RULE3 RULE4 RULE10
        assign p2_alt_out[i] = timer3_out;
        assign ext_irq_line31 = port2_function_enable_reg[i]
                              & ~port2_alternate_select_reg[i]
                              & p2_pin_sync[i]; // RULE3 RULE4 RULE10
      end else begin : g_none
        assign p2_alt_oe[i] = 1'b0;
        assign p2_alt_out[i] = 1'b0;
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // port 3 routing
  // --------------------------------------------------------------------------

  // pin drive: latch under direction in port mode, peripheral in control mode
  always_comb begin
    p3_pin_out = port3_pin_data_reg;
    p3_pin_oe = ~port3_direction_reg; // RULE5 RULE7
    if (port3_function_enable_reg[`PPFM_P3_PIN_RX0]) begin
      p3_pin_out[`PPFM_P3_PIN_RX0] = 1'b0;
      p3_pin_oe[`PPFM_P3_PIN_RX0] = 1'b0; // RULE9
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_TX0]) begin
      p3_pin_out[`PPFM_P3_PIN_TX0] = serial0_transmit; // RULE6 RULE8
      p3_pin_oe[`PPFM_P3_PIN_TX0] = 1'b1;
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_RX1]) begin
      p3_pin_out[`PPFM_P3_PIN_RX1] = 1'b0;
      p3_pin_oe[`PPFM_P3_PIN_RX1] = 1'b0; // RULE9
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_TX1]) begin
      p3_pin_out[`PPFM_P3_PIN_TX1] = port3_alternate_select_reg[`PPFM_P3_PIN_TX1]
                                   ? clocked_serial1_out : serial1_transmit; // RULE8 RULE11
      p3_pin_oe[`PPFM_P3_PIN_TX1] = 1'b1;
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_CLK1]) begin
      if (port3_alternate_select_reg[`PPFM_P3_PIN_CLK1]) begin
        p3_pin_out[`PPFM_P3_PIN_CLK1] = clocked_serial1_clock_out; // RULE9 RULE11
        p3_pin_oe[`PPFM_P3_PIN_CLK1] = clocked_serial1_clock_oe;
      end else begin
        p3_pin_out[`PPFM_P3_PIN_CLK1] = serial1_baud_clock_out; // RULE9
        p3_pin_oe[`PPFM_P3_PIN_CLK1] = serial1_baud_clock_oe;
      end
    end
  end

  // peripheral inputs, idle high when their pin is not handed over
  always_comb begin
    serial0_receive = 1'b1;
    serial1_receive = 1'b1;
    clocked_serial1_in = 1'b1;
    serial1_baud_clock = 1'b1;
    clocked_serial1_clock = 1'b1;
    if (port3_function_enable_reg[`PPFM_P3_PIN_RX0]) begin
      serial0_receive = p3_pin_sync[`PPFM_P3_PIN_RX0]; // RULE6 RULE9
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_RX1]) begin
      if (port3_alternate_select_reg[`PPFM_P3_PIN_RX1]) begin
        clocked_serial1_in = p3_pin_sync[`PPFM_P3_PIN_RX1]; // RULE9 RULE11
      end else begin
        serial1_receive = p3_pin_sync[`PPFM_P3_PIN_RX1]; // RULE9
      end
    end
    if (port3_function_enable_reg[`PPFM_P3_PIN_CLK1]) begin
      if (port3_alternate_select_reg[`PPFM_P3_PIN_CLK1]) begin
        clocked_serial1_clock = p3_pin_sync[`PPFM_P3_PIN_CLK1]; // RULE6 RULE11
      end else begin
        serial1_baud_clock = p3_pin_sync[`PPFM_P3_PIN_CLK1]; // RULE6
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/ppfm_bench.sv
// self-checking bench for the port pin mux
`timescale 1ns/1ps
`default_nettype none
`include "ppfm_consts.svh"

module ppfm_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf, timer2_outputs, ext_irq_lines_b;
  logic [7:0] p2_ext = 8'h00, p2_pin_in, p2_alt_out, p2_alt_oe, port2_function_enable;
  logic [4:0] p3_ext = 5'h0a, p3_pin_in, p3_pin_out, p3_pin_oe;
  logic timer3_out, ext_irq_line31, serial0_transmit, serial1_transmit, clocked_serial1_out;
  logic serial1_baud_clock_out, serial1_baud_clock_oe, clocked_serial1_clock_out;
  logic clocked_serial1_clock_oe, serial0_receive, serial1_receive, clocked_serial1_in;
  logic serial1_baud_clock, clocked_serial1_clock;
  int err_count = 0, comparisons = 0;

  // pin levels: own drive where enabled, outside level otherwise
  assign p2_pin_in = (p2_alt_out & p2_alt_oe) | (p2_ext & ~p2_alt_oe);
  assign p3_pin_in = (p3_pin_out & p3_pin_oe) | (p3_ext & ~p3_pin_oe);

  initial forever #2 ref_clk = ~ref_clk;

  ppfm_top dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .p2_pin_in, .p2_alt_out, .p2_alt_oe, .port2_function_enable, .timer3_out,
    .timer2_outputs, .ext_irq_line31, .ext_irq_lines_b, .p3_pin_in, .p3_pin_out, .p3_pin_oe,
    .serial0_transmit, .serial1_transmit, .clocked_serial1_out, .serial1_baud_clock_out,
    .serial1_baud_clock_oe, .clocked_serial1_clock_out, .clocked_serial1_clock_oe,
    .serial0_receive, .serial1_receive, .clocked_serial1_in, .serial1_baud_clock,
    .clocked_serial1_clock);
  ppfm_periph u_periph (.ref_clk, .rst_n, .timer3_out, .timer2_outputs, .serial0_transmit,
    .serial1_transmit, .clocked_serial1_out, .serial1_baud_clock_out, .serial1_baud_clock_oe,
    .clocked_serial1_clock_out, .clocked_serial1_clock_oe);

  // ---------------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------------
  function automatic logic [13:0] ad(input logic [31:0] idx);
    ad = 14'((idx << 2) & 32'h0000_1fff);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high or 20 access cycles pass
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the hundred or so cycles the tests take
  initial begin
    #40000;
    err_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(ad(`PPFM_IDX_P3_DIR), 32'h0000_00ff);
    rdchk(ad(`PPFM_IDX_P3_FUNC), 32'h0000_0000);
    rdchk(ad(`PPFM_IDX_P2_ALT), 32'h0000_0000);
    rdchk(ad(`PPFM_IDX_P2_FUNC), 32'h0000_0000);
    rdchk(ad(`PPFM_IDX_P3_ALT), 32'h0000_0000);
    rdchk(ad(`PPFM_IDX_P3_DATA), 32'h0000_000a);
    apb(1'b0, 14'h0000, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    // port 2: selector alone does nothing, then control mode
    apb(1'b1, ad(`PPFM_IDX_P2_ALT), 32'h0000_0084);
    rdchk(ad(`PPFM_IDX_P2_ALT), 32'h0000_0084);
    p2_ext <= 8'hff;
    repeat (4) @(negedge ref_clk);
    check(32'(p2_alt_oe), 32'h0000_0000);
    check(32'(ext_irq_lines_b), 32'h0000_0000);
    apb(1'b1, ad(`PPFM_IDX_P2_FUNC), 32'h0000_009e);
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      check(32'(p2_alt_oe), 32'h0000_0084);
      check(32'(p2_alt_out[7]), 32'(timer3_out));
      check(32'(p2_alt_out[2]), 32'(timer2_outputs[1]));
      check(32'({ext_irq_line31, ext_irq_lines_b}), 32'h0000_000d);
    end
    // single-bit clear of pin 7 selector hands the pin to its irq line
    apb(1'b1, ad(`PPFM_IDX_P2_ALT) | 14'h2000, 32'h0000_0080);
    rdchk(ad(`PPFM_IDX_P2_ALT), 32'h0000_0004);
    repeat (3) @(negedge ref_clk);
    check(32'(ext_irq_line31), 32'h0000_0001);
    // port 3 in port mode
    apb(1'b1, ad(`PPFM_IDX_P3_DATA), 32'h0000_0015);
    apb(1'b1, ad(`PPFM_IDX_P3_DIR), 32'h0000_0000);
    rdchk(ad(`PPFM_IDX_P3_DIR), 32'h0000_00e0);
    rdchk(ad(`PPFM_IDX_P3_DATA), 32'h0000_0015);
    @(negedge ref_clk);
    check(32'(p3_pin_oe), 32'h0000_001f);
    check(32'(p3_pin_out), 32'h0000_0015);
    apb(1'b1, ad(`PPFM_IDX_P3_DIR) | 14'h2000, 32'h0000_0101);
    pstrb <= 4'h0;
    apb(1'b1, ad(`PPFM_IDX_P3_DATA), 32'h0000_0000);
    pstrb <= 4'hf;
    repeat (3) @(posedge ref_clk);
    rdchk(ad(`PPFM_IDX_P3_DIR), 32'h0000_00e1);
    rdchk(ad(`PPFM_IDX_P3_DATA), 32'h0000_0014);
    // port 3 handed to the serial units, asynchronous then clocked
    apb(1'b1, ad(`PPFM_IDX_P3_FUNC), 32'h0000_00ff);
    rdchk(ad(`PPFM_IDX_P3_FUNC), 32'h0000_001f);
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, ad(`PPFM_IDX_P3_ALT), a ? 32'h0000_001c : 32'h0000_0000);
      repeat (3) @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        @(negedge ref_clk);
        check(32'(p3_pin_oe[3:0]), 32'h0000_000a);
        check(32'(p3_pin_out[1]), 32'(serial0_transmit));
        check(32'(p3_pin_out[3]), 32'(a ? clocked_serial1_out : serial1_transmit));
        check(32'(p3_pin_oe[4]), 32'(a ? clocked_serial1_clock_oe : serial1_baud_clock_oe));
        check(32'(p3_pin_out[4]), 32'(a ? clocked_serial1_clock_out : serial1_baud_clock_out));
      end
      check(32'(serial0_receive), 32'(p3_ext[0]));
      check(32'(a ? clocked_serial1_in : serial1_receive), 32'(p3_ext[2]));
      check(32'(a ? serial1_receive : clocked_serial1_in), 32'h0000_0001);
      check(32'(a ? serial1_baud_clock : clocked_serial1_clock), 32'h0000_0001);
    end
    print_verdict();
  end
endmodule

`default_nettype wire

// file: verification/ppfm_periph.sv
// behavioural model of the timer and serial peripherals beside the pin mux
`timescale 1ns/1ps
`default_nettype none

module ppfm_periph (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic timer3_out,
  output logic [3:0] timer2_outputs,
  output logic serial0_transmit,
  output logic serial1_transmit,
  output logic clocked_serial1_out,
  output logic serial1_baud_clock_out,
  output logic serial1_baud_clock_oe,
  output logic clocked_serial1_clock_out,
  output logic clocked_serial1_clock_oe
);
  logic [7:0] cnt_reg;

  // free running count, outputs on bit 0 change every cycle, the others every 2 to 16 cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // peripheral drive values taken from the pattern
  assign timer3_out = cnt_reg[0];
  assign timer2_outputs = cnt_reg[4:1];
  assign serial0_transmit = cnt_reg[1];
  assign serial1_transmit = cnt_reg[2];
  assign clocked_serial1_out = ~cnt_reg[2];
  assign serial1_baud_clock_out = cnt_reg[0];
  assign serial1_baud_clock_oe = cnt_reg[3];
  assign clocked_serial1_clock_out = ~cnt_reg[0];
  assign clocked_serial1_clock_oe = ~cnt_reg[3];
endmodule

`default_nettype wire

// file: verification/ppfm_top_assertions.sv
// concurrent checks on the ports of the port pin mux
`timescale 1ns/1ps
`default_nettype none

module ppfm_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] p2_pin_in,
  input wire logic [7:0] p2_alt_out,
  input wire logic [7:0] p2_alt_oe,
  input wire logic [7:0] port2_function_enable,
  input wire logic timer3_out,
  input wire logic [3:0] timer2_outputs,
  input wire logic ext_irq_line31,
  input wire logic [3:0] ext_irq_lines_b,
  input wire logic [4:0] p3_pin_in,
  input wire logic [4:0] p3_pin_oe,
  input wire logic serial0_receive
);
  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence acc_s;
    psel && penable;
  endsequence

  chk_ready_high: assert property (acc_s |-> pready)
    else $error("pready low in access phase");
  chk_err_zero: assert property (acc_s ##0 pslverr |-> prdata == 32'h0000_0000)
    else $error("error response carries data");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    (p3_pin_oe == 5'h00 && p2_alt_oe == 8'h00 && port2_function_enable == 8'h00))
    else $error("outputs not quiet after reset");
  chk_alt_value: assert property ((p2_alt_oe[4:1] & (p2_alt_out[4:1] ^ timer2_outputs)) == 4'h0
    && (!p2_alt_oe[7] || p2_alt_out[7] == timer3_out))
    else $error("timer value not on port 2 pin");
  chk_alt_gated: assert property ((p2_alt_oe & ~port2_function_enable) == 8'h00)
    else $error("port mode pin driven by timer");
  chk_alt_pins: assert property ((p2_alt_oe & 8'h61) == 8'h00)
    else $error("timer drive on pin without timer");
  chk_irq_gated: assert property ((ext_irq_lines_b & ~port2_function_enable[4:1]) == 4'h0
    && (!ext_irq_line31 || port2_function_enable[7]))
    else $error("irq line active in port mode");
  chk_irq_excl: assert property ((ext_irq_lines_b & p2_alt_oe[4:1]) == 4'h0
    && !(ext_irq_line31 && p2_alt_oe[7]))
    else $error("irq and timer on one pin");
  chk_irq_pin: assert property (ext_irq_line31 |-> $past(p2_pin_in[7], 2))
    else $error("irq line without pin level");
  chk_rx0_pin: assert property (!serial0_receive |-> !$past(p3_pin_in[0], 2))
    else $error("receive low without pin level");
endmodule

bind ppfm_top ppfm_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .prdata, .pready, .pslverr,
  .p2_pin_in, .p2_alt_out, .p2_alt_oe, .port2_function_enable, .timer3_out, .timer2_outputs,
  .ext_irq_line31, .ext_irq_lines_b, .p3_pin_in, .p3_pin_oe, .serial0_receive);

`default_nettype wire
